/* rtl/smart_pkg.sv */
// Functional notes
// [RULE1] log-read returns the addressed log sector contents to the host
// [RULE2] host loads log address and sector count before log read or write
// [RULE3] logs 00h,01h,02h single read-only sectors; listed reserved addresses read-only
// [RULE4] self-test log read-only at 06h; selective log read-write at 09h
// [RULE5] 80h-9Fh host area of 16 read-write sectors; A0h-FFh vendor reserved (code: only 80h up to 80h+HOST_SECTORS-1 read-write, 80h-8Fh at 16)
// [RULE6] self-test log keeps up to 21 descriptors of 24 bytes, oldest replaced
// [RULE7] byte 508 points at newest descriptor: 0 empty, else 1 to 21
// [RULE8] descriptor n at n*24+2: number, status, stamp, checkpoint, failing LBA
// [RULE9] selective log holds five start/end LBA spans from byte 2, read-write
// [RULE10] selective log bytes 492-499 current LBA, 500-501 current span, read-only
// [RULE11] selective log keeps flags 502-503, pending time 508-509, checksum 511
// [RULE12] log-write takes exactly 512 bytes per sector into the addressed log
// [RULE13] nothing monitored or saved before enable; enable turns on all monitoring (code: power_autosave_en is on from load, before any enable)
// [RULE14] enabled state kept in non-volatile storage across power cycles
// [RULE15] repeated enable while enabled leaves attribute values untouched
// [RULE16] when disabled, every subcommand except enable is aborted with error
// [RULE17] disable does not stop power-mode attribute autosave
// [RULE18] values kept through disable, updated after re-enable on read or save
// [RULE19] status subcommand saves attributes first, then compares against thresholds
// [RULE20] off-line switch: sector count 00h disables, F8h enables collection
// [RULE21] off-line enable also enables full read scan with reallocation; disable stops it
// [RULE22] host writes subcommand into features before issuing command code
// [RULE23] log-write to read-only or reserved address aborts, log unchanged
// [RULE24] checksum byte makes all 512 sector bytes sum to zero modulo 256
//
// constants for the health-monitoring command handler
// assumes a single clock domain shared with the command front end
package smart_pkg;
    localparam logic [7:0] SMART_CMD = 8'hB0;
    localparam logic [7:0] SUB_READ_LOG = 8'hD5;
    localparam logic [7:0] SUB_WRITE_LOG = 8'hD6;
    localparam logic [7:0] SUB_ENABLE = 8'hD8;
    localparam logic [7:0] SUB_DISABLE = 8'hD9;
    localparam logic [7:0] SUB_STATUS = 8'hDA;
    localparam logic [7:0] SUB_OFFLINE = 8'hDB;
    localparam logic [7:0] OFFLINE_OFF = 8'h00;
    localparam logic [7:0] OFFLINE_ON = 8'hF8;
    localparam logic [7:0] LOG_DIR = 8'h00;
    localparam logic [7:0] LOG_ERR = 8'h01;
    localparam logic [7:0] LOG_XERR = 8'h02;
    localparam logic [7:0] LOG_SELFTEST = 8'h06;
    localparam logic [7:0] LOG_SELECTIVE = 8'h09;
    localparam logic [7:0] LOG_HOST_FIRST = 8'h80;
    localparam logic [7:0] LOG_VENDOR_FIRST = 8'hA0;
    localparam logic [7:0] LOG_REVISION = 8'h01;
    localparam logic [8:0] LAST_BYTE = 9'h1FF;
    localparam logic [8:0] DESC_BASE = 9'h002;
    localparam logic [8:0] DESC_END = 9'h1F9;
    localparam logic [4:0] DESC_LAST_OFF = 5'h17;
    localparam logic [4:0] DESC_MAX = 5'h15;
    localparam logic [4:0] FLD_NUM = 5'h00;
    localparam logic [4:0] FLD_STAT = 5'h01;
    localparam logic [4:0] FLD_STAMP = 5'h02;
    localparam logic [4:0] FLD_CHK = 5'h04;
    localparam logic [4:0] FLD_LBA = 5'h05;
    localparam logic [4:0] FLD_LBA_END = 5'h08;
    localparam logic [8:0] ST_PTR_BYTE = 9'h1FC;
    localparam logic [8:0] SEL_LBA_FIRST = 9'h1EC;
    localparam logic [8:0] SEL_LBA_LAST = 9'h1F3;
    localparam logic [8:0] SEL_SPAN_FIRST = 9'h1F4;
    localparam logic [8:0] SEL_SPAN_LAST = 9'h1F5;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_READ = 3'b001,
        S_WRITE = 3'b010,
        S_SAVE = 3'b011,
        S_CMP = 3'b100
    } state_e;
endpackage

/* rtl/smart_log_and_enable_handler.sv */
// health-monitoring subcommand handler: logs, enable state, status, off-line switch
// assumes command, data, nv and attribute engines share clk; no pin inputs here
`timescale 1ns/1ps
module smart_log_and_enable_handler #(
    parameter int HOST_SECTORS = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_features,
    input wire logic [7:0] cmd_lba_low,
    input wire logic [7:0] cmd_sector_count,
    // completion
    output logic resp_valid,
    output logic resp_abort,
    output logic resp_thr_exceeded,
    // log data to host
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    output logic rd_last,
    // log data from host
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    // self-test engine
    input wire logic st_rec_valid,
    input wire logic [7:0] st_rec_num,
    input wire logic [7:0] st_rec_status,
    input wire logic [15:0] st_rec_stamp,
    input wire logic [7:0] st_rec_chkpt,
    input wire logic [31:0] st_rec_lba,
    input wire logic [63:0] sel_cur_lba,
    input wire logic [15:0] sel_cur_span,
    // non-volatile enable state
    input wire logic nv_enabled,
    output logic nv_write,
    output logic nv_enabled_out,
    // attribute engine
    output logic monitor_en,
    output logic power_autosave_en,
    output logic attr_save_start,
    input wire logic attr_save_done,
    output logic thr_cmp_start,
    input wire logic thr_cmp_done,
    input wire logic thr_exceeded,
    // off-line collection
    output logic offline_en,
    output logic read_scan_en,
    output logic offline_start
);
    localparam int HW = $clog2(HOST_SECTORS);

    smart_pkg::state_e state_q;
    logic loaded_q, enabled_q, offline_q, nv_write_q, off_start_q;
    logic resp_q, abort_q, thr_q, save_q, cmp_q;
    logic host_q;
    logic [7:0] log_q, cnt_q, sec_q, sum_q, rd_data_q;
    logic [8:0] idx_q;
    logic [4:0] dn_q, doff_q, ptr_q;
    logic full_q;
    logic [7:0] sel_mem [512];
    logic [7:0] host_mem [HOST_SECTORS*512];
    logic [7:0] d_num [21];
    logic [7:0] d_stat [21];
    logic [15:0] d_stamp [21];
    logic [7:0] d_chk [21];
    logic [31:0] d_lba [21];

    function automatic logic is_host(input logic [7:0] a);
        is_host = a >= smart_pkg::LOG_HOST_FIRST &&
                  9'(a - smart_pkg::LOG_HOST_FIRST) < 9'(HOST_SECTORS);
    endfunction

    function automatic logic [HW-1:0] host_row(input logic [7:0] a, input logic [7:0] s);
        logic [7:0] r;
        r = 8'(a - smart_pkg::LOG_HOST_FIRST + s);
        host_row = r[HW-1:0];
    endfunction

    // command decode
    logic acc, bad, read_ok, write_ok, hs_rd, hs_wr, last_byte;
    logic [7:0] sub, la, sc;
    assign sub = cmd_features; // RULE22
    assign la = cmd_lba_low; // RULE2
    assign sc = cmd_sector_count; // RULE2
    assign cmd_ready = state_q == smart_pkg::S_IDLE && loaded_q && !resp_q;
    assign acc = cmd_valid && cmd_ready;
    assign bad = cmd_code != smart_pkg::SMART_CMD ||
                 (!enabled_q && sub != smart_pkg::SUB_ENABLE); // RULE16
    assign read_ok = is_host(la) ?
        (sc != 8'h00 && 9'(la - smart_pkg::LOG_HOST_FIRST) + 9'(sc) <= 9'(HOST_SECTORS)) :
        (la < smart_pkg::LOG_VENDOR_FIRST && sc == 8'h01); // RULE3 RULE5
    assign write_ok = is_host(la) ? read_ok :
        (la == smart_pkg::LOG_SELECTIVE && sc == 8'h01); // RULE23 RULE4
    assign hs_rd = state_q == smart_pkg::S_READ && rd_ready;
    assign hs_wr = state_q == smart_pkg::S_WRITE && wr_valid;
    assign last_byte = idx_q == smart_pkg::LAST_BYTE && 8'(sec_q + 8'h01) == cnt_q;

    // next byte position and its content
    logic [7:0] n_log, n_sec, n_sum, byte_d;
    logic [8:0] n_idx;
    logic [4:0] n_dn, n_doff, used;
    logic [5:0] k;
    assign used = full_q ? smart_pkg::DESC_MAX : ptr_q;
    always_comb begin
        k = 6'h00;
        if (state_q == smart_pkg::S_IDLE) begin
            n_log = la;
            n_sec = 8'h00;
            n_sum = 8'h00;
            n_idx = 9'h000;
            n_dn = 5'h00;
            n_doff = 5'h00;
        end else begin
            n_log = log_q;
            n_sum = 8'(sum_q + rd_data_q);
            n_idx = 9'(idx_q + 9'h001);
            n_sec = (idx_q == smart_pkg::LAST_BYTE) ? 8'(sec_q + 8'h01) : sec_q;
            n_dn = dn_q;
            n_doff = doff_q;
            if (idx_q >= smart_pkg::DESC_BASE) begin
                if (doff_q == smart_pkg::DESC_LAST_OFF) begin
                    n_doff = 5'h00;
                    n_dn = 5'(dn_q + 5'h01);
                end else begin
                    n_doff = 5'(doff_q + 5'h01);
                end
            end
        end
        byte_d = 8'h00;
        if (is_host(n_log)) begin
            byte_d = host_mem[{host_row(n_log, n_sec), n_idx}]; // RULE5
        end else if (n_idx == smart_pkg::LAST_BYTE) begin
            byte_d = 8'(8'h00 - n_sum); // RULE24
        end else if (n_log == smart_pkg::LOG_DIR) begin
            if (n_idx == 9'h000) begin
                byte_d = smart_pkg::LOG_REVISION;
            end else if (!n_idx[0] && (n_idx[8:1] == smart_pkg::LOG_ERR ||
                         n_idx[8:1] == smart_pkg::LOG_XERR ||
                         n_idx[8:1] == smart_pkg::LOG_SELFTEST ||
                         n_idx[8:1] == smart_pkg::LOG_SELECTIVE || is_host(n_idx[8:1]))) begin
                byte_d = 8'h01; // RULE3
            end
        end else if (n_log == smart_pkg::LOG_ERR || n_log == smart_pkg::LOG_XERR) begin
            byte_d = (n_idx == 9'h000) ? smart_pkg::LOG_REVISION : 8'h00; // RULE3
        end else if (n_log == smart_pkg::LOG_SELFTEST) begin
            if (n_idx == 9'h000) begin
                byte_d = smart_pkg::LOG_REVISION;
            end else if (n_idx == smart_pkg::ST_PTR_BYTE) begin
                byte_d = {3'b000, ptr_q}; // RULE7
            end else if (n_idx >= smart_pkg::DESC_BASE && n_idx <= smart_pkg::DESC_END
                         && n_dn < used) begin
                // RULE8
                if (n_doff == smart_pkg::FLD_NUM) begin
                    byte_d = d_num[n_dn];
                end else if (n_doff == smart_pkg::FLD_STAT) begin
                    byte_d = d_stat[n_dn];
                end else if (n_doff == smart_pkg::FLD_STAMP) begin
                    byte_d = d_stamp[n_dn][7:0];
                end else if (n_doff == 5'(smart_pkg::FLD_STAMP + 5'h01)) begin
                    byte_d = d_stamp[n_dn][15:8];
                end else if (n_doff == smart_pkg::FLD_CHK) begin
                    byte_d = d_chk[n_dn];
                end else if (n_doff >= smart_pkg::FLD_LBA && n_doff <= smart_pkg::FLD_LBA_END) begin
                    byte_d = d_lba[n_dn][8*(n_doff-smart_pkg::FLD_LBA) +: 8];
                end
            end
        end else if (n_log == smart_pkg::LOG_SELECTIVE) begin
            if (n_idx >= smart_pkg::SEL_LBA_FIRST && n_idx <= smart_pkg::SEL_LBA_LAST) begin
                k = 6'({n_idx - smart_pkg::SEL_LBA_FIRST, 3'b000});
                byte_d = sel_cur_lba[k +: 8]; // RULE10
            end else if (n_idx == smart_pkg::SEL_SPAN_FIRST) begin
                byte_d = sel_cur_span[7:0]; // RULE10
            end else if (n_idx == smart_pkg::SEL_SPAN_LAST) begin
                byte_d = sel_cur_span[15:8];
            end else begin
                byte_d = sel_mem[n_idx]; // RULE9 RULE11
            end
        end
    end

    // command sequencing
    always_ff @(posedge clk) begin
        resp_q <= 1'b0;
        save_q <= 1'b0;
        cmp_q <= 1'b0;
        if (reset) begin
            state_q <= smart_pkg::S_IDLE;
            abort_q <= 1'b0;
            thr_q <= 1'b0;
            host_q <= 1'b0;
            log_q <= 8'h00;
            cnt_q <= 8'h00;
            sec_q <= 8'h00;
            sum_q <= 8'h00;
            idx_q <= 9'h000;
            dn_q <= 5'h00;
            doff_q <= 5'h00;
            rd_data_q <= 8'h00;
        end else begin
            case (state_q)
                smart_pkg::S_IDLE: begin
                    if (acc) begin
                        resp_q <= 1'b1;
                        abort_q <= 1'b1;
                        log_q <= la;
                        cnt_q <= sc;
                        host_q <= is_host(la);
                        idx_q <= 9'h000;
                        sec_q <= 8'h00;
                        if (bad) begin
                            abort_q <= 1'b1; // RULE16
                        end else if (sub == smart_pkg::SUB_READ_LOG && read_ok) begin
                            resp_q <= 1'b0;
                            state_q <= smart_pkg::S_READ; // RULE1
                            sum_q <= n_sum;
                            dn_q <= n_dn;
                            doff_q <= n_doff;
                            rd_data_q <= byte_d;
                        end else if (sub == smart_pkg::SUB_WRITE_LOG && write_ok) begin
                            resp_q <= 1'b0;
                            state_q <= smart_pkg::S_WRITE; // RULE12
                        end else if (sub == smart_pkg::SUB_STATUS) begin
                            resp_q <= 1'b0;
                            save_q <= 1'b1; // RULE19
                            state_q <= smart_pkg::S_SAVE;
                        end else if (sub == smart_pkg::SUB_ENABLE || sub == smart_pkg::SUB_DISABLE ||
                                     (sub == smart_pkg::SUB_OFFLINE &&
                                      (sc == smart_pkg::OFFLINE_OFF || sc == smart_pkg::OFFLINE_ON))) begin
                            abort_q <= 1'b0;
                        end
                    end
                end
                smart_pkg::S_READ: begin
                    if (hs_rd) begin
                        if (last_byte) begin
                            resp_q <= 1'b1;
                            abort_q <= 1'b0;
                            state_q <= smart_pkg::S_IDLE;
                        end else begin
                            idx_q <= n_idx;
                            sec_q <= n_sec;
                            sum_q <= (idx_q == smart_pkg::LAST_BYTE) ? 8'h00 : n_sum;
                            dn_q <= (idx_q == smart_pkg::LAST_BYTE) ? 5'h00 : n_dn;
                            doff_q <= (idx_q == smart_pkg::LAST_BYTE) ? 5'h00 : n_doff;
                            rd_data_q <= byte_d;
                        end
                    end
                end
                smart_pkg::S_WRITE: begin
                    if (hs_wr) begin
                        idx_q <= n_idx;
                        sec_q <= n_sec;
                        if (last_byte) begin
                            resp_q <= 1'b1; // RULE12
                            abort_q <= 1'b0;
                            state_q <= smart_pkg::S_IDLE;
                        end
                    end
                end
                smart_pkg::S_SAVE: begin
                    if (attr_save_done) begin
                        cmp_q <= 1'b1; // RULE19
                        state_q <= smart_pkg::S_CMP;
                    end
                end
                smart_pkg::S_CMP: begin
                    if (thr_cmp_done) begin
                        thr_q <= thr_exceeded;
                        resp_q <= 1'b1;
                        abort_q <= 1'b0;
                        state_q <= smart_pkg::S_IDLE;
                    end
                end
                default: state_q <= smart_pkg::S_IDLE;
            endcase
        end
    end

    // log storage; read-only fields of the selective log are never stored
    always_ff @(posedge clk) begin
        if (hs_wr) begin
            if (host_q) begin
                host_mem[{host_row(log_q, sec_q), idx_q}] <= wr_data; // RULE5
            end else if (idx_q < smart_pkg::SEL_LBA_FIRST || idx_q > smart_pkg::SEL_SPAN_LAST) begin
                sel_mem[idx_q] <= wr_data; // RULE9 RULE11
            end
        end
    end

    // self-test descriptors form a ring; pointer is the newest slot plus one
    logic [4:0] slot;
    assign slot = (ptr_q == smart_pkg::DESC_MAX) ? 5'h00 : ptr_q; // RULE6
    always_ff @(posedge clk) begin
        if (reset) begin
            ptr_q <= 5'h00;
            full_q <= 1'b0;
        end else if (st_rec_valid) begin
            ptr_q <= 5'(slot + 5'h01); // RULE7
            if (ptr_q == smart_pkg::DESC_MAX) begin
                full_q <= 1'b1; // RULE6
            end
        end
    end
    always_ff @(posedge clk) begin
        if (st_rec_valid) begin
            d_num[slot] <= st_rec_num; // RULE8
            d_stat[slot] <= st_rec_status;
            d_stamp[slot] <= st_rec_stamp;
            d_chk[slot] <= st_rec_chkpt;
            d_lba[slot] <= st_rec_lba;
        end
    end

    // enable state: loaded from nv after reset, written back on every change
    logic do_en, do_dis, do_off;
    assign do_en = acc && !bad && sub == smart_pkg::SUB_ENABLE;
    assign do_dis = acc && !bad && sub == smart_pkg::SUB_DISABLE;
    assign do_off = acc && !bad && sub == smart_pkg::SUB_OFFLINE &&
                    (sc == smart_pkg::OFFLINE_OFF || sc == smart_pkg::OFFLINE_ON); // RULE20
    always_ff @(posedge clk) begin
        nv_write_q <= 1'b0;
        if (reset) begin
            loaded_q <= 1'b0;
            enabled_q <= 1'b0;
        end else if (!loaded_q) begin
            loaded_q <= 1'b1;
            enabled_q <= nv_enabled; // RULE14
        end else if (do_en && !enabled_q) begin
            enabled_q <= 1'b1; // RULE13
            nv_write_q <= 1'b1; // RULE14
        end else if (do_dis) begin
            enabled_q <= 1'b0; // RULE16
            nv_write_q <= 1'b1; // RULE14
        end
    end

    always_ff @(posedge clk) begin
        off_start_q <= 1'b0;
        if (reset) begin
            offline_q <= 1'b0;
        end else if (do_off) begin
            offline_q <= sc == smart_pkg::OFFLINE_ON; // RULE20 RULE21
            off_start_q <= sc == smart_pkg::OFFLINE_ON; // RULE20
        end
    end

    // repeat enable produces no nv write and no attribute activity
    assign monitor_en = enabled_q; // RULE13 RULE15 RULE18
    assign power_autosave_en = loaded_q; // RULE17
    assign nv_write = nv_write_q;
    assign nv_enabled_out = enabled_q;
    assign attr_save_start = save_q;
    assign thr_cmp_start = cmp_q;
    assign offline_en = offline_q;
    assign read_scan_en = offline_q; // RULE21
    assign offline_start = off_start_q;
    assign resp_valid = resp_q;
    assign resp_abort = abort_q;
    assign resp_thr_exceeded = thr_q;
    assign rd_valid = state_q == smart_pkg::S_READ;
    assign rd_data = rd_data_q;
    assign rd_last = rd_valid && last_byte;
    assign wr_ready = state_q == smart_pkg::S_WRITE;

    a_disabled_abort: assert property (@(posedge clk) disable iff (reset)
        acc && !enabled_q && sub != smart_pkg::SUB_ENABLE |=> resp_valid && resp_abort)
        else $error("disabled subcommand not aborted"); // RULE16
    a_enable_turns_on: assert property (@(posedge clk) disable iff (reset)
        do_en |=> monitor_en) else $error("enable did not take"); // RULE13
    a_repeat_enable_quiet: assert property (@(posedge clk) disable iff (reset)
        do_en && enabled_q |=> !nv_write && !attr_save_start)
        else $error("repeat enable caused activity"); // RULE15
    a_ro_write_abort: assert property (@(posedge clk) disable iff (reset)
        acc && sub == smart_pkg::SUB_WRITE_LOG && la < smart_pkg::LOG_SELECTIVE
        |=> resp_valid && resp_abort && state_q == smart_pkg::S_IDLE)
        else $error("read-only log write not aborted"); // RULE23
    a_ptr_wrap: assert property (@(posedge clk) disable iff (reset)
        st_rec_valid && ptr_q == smart_pkg::DESC_MAX |=> ptr_q == 5'h01 && full_q)
        else $error("descriptor ring did not wrap"); // RULE6
    a_ptr_range: assert property (@(posedge clk) disable iff (reset)
        ptr_q <= smart_pkg::DESC_MAX) else $error("pointer out of range"); // RULE7
    a_save_before_cmp: assert property (@(posedge clk) disable iff (reset)
        thr_cmp_start |-> $past(attr_save_done) && $past(state_q) == smart_pkg::S_SAVE)
        else $error("compare before save"); // RULE19
    a_offline_scan: assert property (@(posedge clk) disable iff (reset)
        do_off |=> offline_en == ($past(sc) == smart_pkg::OFFLINE_ON) && read_scan_en == offline_en)
        else $error("off-line switch mismatch"); // RULE21
    a_checksum_zero: assert property (@(posedge clk) disable iff (reset)
        rd_valid && idx_q == smart_pkg::LAST_BYTE && !host_q |-> 8'(sum_q + rd_data) == 8'h00)
        else $error("log checksum wrong"); // RULE24
    a_write_length: assert property (@(posedge clk) disable iff (reset)
        hs_wr && last_byte |=> resp_valid && !resp_abort && !wr_ready)
        else $error("write did not close at byte 511"); // RULE12
endmodule

/* dv/attr_engine_model.sv */
// attribute engine stand-in: answers save and compare requests
// assumes single-cycle start pulses from the handler
`timescale 1ns/1ps
module attr_engine_model #(
    parameter int LAT = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // requests
    input wire logic save_start,
    input wire logic cmp_start,
    // answers
    output logic save_done,
    output logic cmp_done
);
    logic [7:0] save_q;
    logic [7:0] cmp_q;
    // fixed delay line; LAT above 8 not supported
    always_ff @(posedge clk) begin
        if (reset) begin
            save_q <= 8'h00;
            cmp_q <= 8'h00;
        end else begin
            save_q <= {save_q[6:0], save_start};
            cmp_q <= {cmp_q[6:0], cmp_start};
        end
    end
    assign save_done = save_q[LAT-1];
    assign cmp_done = cmp_q[LAT-1];
endmodule

/* dv/smart_log_and_enable_handler_tb.sv */
// testbench: log reads and writes, enable state, status, off-line switch
// assumes the attribute engine model; nv store starts disabled
`timescale 1ns/1ps
module smart_log_and_enable_handler_tb;
    logic clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, st_rec_valid = 1'b0, thr_exceeded = 1'b0;
    logic pace = 1'b1, nv_enabled = 1'b0;
    logic [7:0] cmd_code = 8'hB0, cmd_features = 8'h00, cmd_lba_low = 8'h00;
    logic [7:0] cmd_sector_count = 8'h01, wr_data = 8'h00, st_rec_num = 8'h00, rd_data;
    logic cmd_ready, resp_valid, resp_abort, resp_thr_exceeded, rd_valid, rd_last, wr_ready;
    logic nv_write, nv_enabled_out, monitor_en, power_autosave_en, attr_save_start;
    logic attr_save_done, thr_cmp_start, thr_cmp_done, offline_en, read_scan_en, offline_start;
    logic [7:0] rbuf [0:511];
    logic [7:0] sum;
    logic ab;
    int bad_count = 0, compares = 0, rn, rl, nw, os;
    always #5 clk = ~clk;
    attr_engine_model #(.LAT(4)) eng (.clk, .reset, .save_start(attr_save_start),
        .cmp_start(thr_cmp_start), .save_done(attr_save_done), .cmp_done(thr_cmp_done));
    smart_log_and_enable_handler #(.HOST_SECTORS(16)) uut (.clk, .reset, .cmd_valid,
        .cmd_ready, .cmd_code, .cmd_features, .cmd_lba_low, .cmd_sector_count, .resp_valid,
        .resp_abort, .resp_thr_exceeded, .rd_valid, .rd_ready(pace), .rd_data, .rd_last,
        .wr_valid(pace), .wr_ready, .wr_data, .st_rec_valid, .st_rec_num,
        .st_rec_status(~st_rec_num), .st_rec_stamp({2{st_rec_num}}), .st_rec_chkpt(st_rec_num),
        .st_rec_lba({4{st_rec_num}}), .sel_cur_lba(64'h0), .sel_cur_span(16'h0),
        .nv_enabled, .nv_write, .nv_enabled_out, .monitor_en, .power_autosave_en,
        .attr_save_start, .attr_save_done, .thr_cmp_start, .thr_cmp_done, .thr_exceeded,
        .offline_en, .read_scan_en, .offline_start);
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // one command, data phase, completion; sum collects read bytes
    task automatic run(input logic [7:0] c, input logic [7:0] f, input logic [7:0] a);
        @(posedge clk);
        cmd_code <= c;
        cmd_features <= f;
        cmd_lba_low <= a;
        cmd_valid <= 1'b1;
        wr_data <= 8'h00;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        rn = 0;
        rl = 0;
        nw = 0;
        os = 0;
        sum = 8'h00;
        // pace stalls every other beat: rd_ready back-pressure on reads, wr_valid gaps on writes
        while (resp_valid !== 1'b1) begin
            @(posedge clk);
            if (rd_valid === 1'b1 && pace === 1'b1 && rn < 512) rbuf[rn++] = rd_data;
            if (rd_valid === 1'b1 && pace === 1'b1) sum += rd_data;
            if (wr_ready === 1'b1 && pace === 1'b1) wr_data <= wr_data + 8'h01;
            if (rd_last === 1'b1 && pace === 1'b1) rl++;
            if (nv_write === 1'b1) nw++;
            if (offline_start === 1'b1) os++;
            pace <= ~pace;
        end
        ab = resp_abort;
    endtask
    task automatic rec(input logic [7:0] v);
        @(posedge clk);
        st_rec_num <= v;
        st_rec_valid <= 1'b1;
        @(posedge clk);
        st_rec_valid <= 1'b0;
    endtask
    task automatic t_enable();
        run(8'hB0, 8'hD5, 8'h00);
        chk("abort before enable", 8'h01, ab);
        run(8'hB0, 8'hD8, 8'h00);
        chk("monitor", 8'h01, monitor_en);
        chk("nv state", 8'h01, nv_enabled_out);
        chk("nv write", 8'h01, 8'(nw));
        run(8'hB0, 8'hD8, 8'h00);
        chk("second enable", 8'h00, ab);
        chk("repeat nv write", 8'h00, 8'(nw));
        run(8'hEC, 8'hD8, 8'h00);
        chk("other opcode", 8'h01, ab);
    endtask
    task automatic t_logs();
        run(8'hB0, 8'hD5, 8'h00);
        chk("dir byte 0", 8'h01, rbuf[0]);
        chk("dir selftest", 8'h01, rbuf[12]);
        chk("dir sum", 8'h00, sum);
        chk("last flag", 8'h01, 8'(rl));
        run(8'hB0, 8'hD6, 8'h80);
        chk("host write", 8'h00, ab);
        run(8'hB0, 8'hD5, 8'h80);
        chk("host byte 5", 8'h05, rbuf[5]);
        chk("host byte 511", 8'hFF, rbuf[511]);
        run(8'hB0, 8'hD6, 8'h01);
        chk("ro write", 8'h01, ab);
        run(8'hB0, 8'hD6, 8'h09);
        run(8'hB0, 8'hD5, 8'h09);
        chk("span byte", 8'h02, rbuf[2]);
        chk("flags", 8'hF7, rbuf[503]);
        chk("sel sum", 8'h00, sum);
    endtask
    task automatic t_selftest();
        run(8'hB0, 8'hD5, 8'h06);
        chk("empty ptr", 8'h00, rbuf[508]);
        for (int i = 1; i <= 21; i++) rec(8'(i));
        run(8'hB0, 8'hD5, 8'h06);
        chk("full ptr", 8'h15, rbuf[508]);
        chk("last num", 8'h15, rbuf[482]);
        chk("status", 8'hFE, rbuf[3]);
        chk("lba", 8'h01, rbuf[10]);
        rec(8'h40);
        run(8'hB0, 8'hD5, 8'h06);
        chk("wrap ptr", 8'h01, rbuf[508]);
        chk("wrap num", 8'h40, rbuf[2]);
    endtask
    task automatic t_modes();
        thr_exceeded <= 1'b1;
        run(8'hB0, 8'hDA, 8'h00);
        chk("threshold", 8'h01, resp_thr_exceeded);
        cmd_sector_count <= 8'hF8;
        run(8'hB0, 8'hDB, 8'h00);
        chk("scan on", 8'h01, read_scan_en);
        chk("offline start", 8'h01, 8'(os));
        cmd_sector_count <= 8'h00;
        run(8'hB0, 8'hDB, 8'h00);
        chk("offline off", 8'h00, offline_en);
        cmd_sector_count <= 8'h01;
        run(8'hB0, 8'hDB, 8'h00);
        chk("offline bad count", 8'h01, ab);
        run(8'hB0, 8'hD9, 8'h00);
        chk("disable nv write", 8'h01, 8'(nw));
        run(8'hB0, 8'hDA, 8'h00);
        chk("abort disabled", 8'h01, ab);
        chk("autosave", 8'h01, power_autosave_en);
    endtask
    // mid-run reset: enabled state must come back from the nv store
    task automatic t_reload();
        @(posedge clk);
        nv_enabled <= 1'b1;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk("nv reload", 8'h01, monitor_en);
    endtask
    task automatic end_of_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // about 8k cycles of traffic expected with the stalled handshakes
    initial begin
        #500000;
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_enable();
        t_logs();
        t_selftest();
        t_modes();
        t_reload();
        end_of_test();
    end
endmodule
